/* core/cfps_core.v */
// instruction sequencing core: phases, fetch pipeline, pc, stack and alu
// assumes a decoder outside presents op, target and alu fields from the
// fetched word, and program memory answers within one phase of the address
`timescale 1ns/100ps
`include "cfps_regs.vh"
module cfps_core
#(
    parameter PCW = 12,
    parameter IWW = 15,
    parameter DEPTH = 8,
    parameter IW = 3,
    parameter [PCW-1:0] INT_VECTOR = 12'h004
)
(
    // clock and reset
    input wire mclk,
    input wire reset,
    // program memory
    output reg [PCW-1:0] pmem_addr_q,
    output reg pmem_rd_q,
    input wire [IWW-1:0] pmem_data,
    // table read request, pointer given by data side
    input wire table_rd,
    input wire [PCW-1:0] table_addr,
    output reg [IWW-1:0] table_data_q,
    output reg table_valid_q,
    // decoded current instruction
    input wire [3:0] dec_op,
    input wire [PCW-1:0] dec_target,
    input wire [4:0] dec_alu_func,
    input wire dec_skip_on_zero,
    input wire dec_to_acc,
    // data operands and write back
    input wire [7:0] mem_operand,
    output reg [7:0] acc_q,
    output reg [7:0] wb_data_q,
    output reg wb_en_q,
    output reg [3:0] status_q,
    // pc low byte access
    input wire pcl_wr,
    input wire [7:0] pcl_wdata,
    output reg [7:0] pc_low_byte_q,
    // interrupt
    input wire int_req,
    output reg int_ack_q,
    output reg int_pending_q,
    // observation
    output reg [3:0] instruction_phases_q,
    output reg [IWW-1:0] ir_q,
    output reg ir_valid_q,
    output reg stack_full_q
);
    localparam S_RUN = 2'b01;
    localparam S_FLUSH = 2'b10;

    reg [PCW-1:0] pc_q;
    reg [PCW-1:0] pc_d;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [PCW-1:0] push_value;
    reg push;
    reg pop;
    reg flush;
    reg ir_valid_d;
    reg table_q;
    wire t1;
    wire t4;
    wire [PCW-1:0] top_value;
    wire full;
    wire empty;
    wire [7:0] alu_result;
    wire [3:0] alu_status;
    wire alu_zero;
    wire [PCW-1:0] pc_plus;
    wire exec_ok;

    assign t1 = instruction_phases_q[0];
    assign t4 = instruction_phases_q[3];
    assign pc_plus = pc_q + `CFPS_PC_ONE;
    // a discarded instruction still occupies its slot but does nothing
    assign exec_ok = ir_valid_q && (state_q == S_RUN);

    // phase ring, one hot, rotates every mclk
    always @(posedge mclk)
    begin
        if (reset)
            instruction_phases_q <= `CFPS_PH_T1;
        else
            instruction_phases_q <= {instruction_phases_q[2:0],
                instruction_phases_q[3]};
    end

    cfps_stack
    #(
        .DEPTH(DEPTH),
        .IW(IW),
        .PCW(PCW)
    )
    u_stack
    (
        .mclk(mclk),
        .reset(reset),
        .push(push),
        .pop(pop),
        .push_value(push_value),
        .top_value(top_value),
        .full(full),
        .empty(empty)
    );

    cfps_alu u_alu
    (
        .op_a(acc_q),
        .op_b(mem_operand),
        .carry_in(status_q[`CFPS_ST_C]),
        .func(dec_alu_func),
        .result(alu_result),
        .status(alu_status),
        .zero_out(alu_zero)
    );

    // sequencing decisions taken at the end of execute (phase four)
    always @*
    begin
        pc_d = pc_q;
        state_d = S_RUN;
        push = 1'b0;
        pop = 1'b0;
        push_value = pc_q;
        flush = 1'b0;
        ir_valid_d = 1'b1;
        if (t4)
        begin
            if (int_pending_q && !full && exec_ok && dec_op != `CFPS_OP_CALL)
            begin
                // acknowledge only with a free level; the fetched word is redone later
                push = 1'b1;
                push_value = pc_q;
                pc_d = INT_VECTOR;
                flush = 1'b1;
            end
            else if (exec_ok)
            begin
                case (dec_op)
                    `CFPS_OP_JUMP:
                    begin
                        pc_d = dec_target;
                        flush = 1'b1;
                    end
                    `CFPS_OP_CALL:
                    begin
                        push = 1'b1;
                        // return lands on the word after the call, not the call again
                        push_value = pc_plus;
                        pc_d = dec_target;
                        flush = 1'b1;
                    end
                    `CFPS_OP_RET, `CFPS_OP_INTERRUPT_RETURN:
                    begin
                        pop = 1'b1;
                        pc_d = top_value;
                        flush = 1'b1;
                    end
                    `CFPS_OP_SKIP:
                    begin
                        if (alu_zero == dec_skip_on_zero)
                            flush = 1'b1;
                    end
                    `CFPS_OP_PCLW:
                    begin
                        pc_d = {pc_q[PCW-1:`CFPS_LOW_BITS], pcl_wdata};
                        flush = 1'b1;
                    end
                    default: pc_d = pc_q;
                endcase
            end
            if (!flush && pcl_wr && exec_ok)
            begin
                // low byte written by a data move: in-page jump plus dummy
                pc_d = {pc_q[PCW-1:`CFPS_LOW_BITS], pcl_wdata};
                flush = 1'b1;
            end
            if (flush)
            begin
                state_d = S_FLUSH;
                ir_valid_d = 1'b0;
            end
        end
        else
            state_d = state_q;
    end

    // pc, pipeline and fetch; pc advances at the start of each T1
    always @(posedge mclk)
    begin
        if (reset)
        begin
            pc_q <= `CFPS_PC_RESET;
            state_q <= S_RUN;
            pmem_addr_q <= `CFPS_PC_RESET;
            pmem_rd_q <= 1'b0;
            ir_q <= {IWW{1'b0}};
            ir_valid_q <= 1'b0;
            table_q <= 1'b0;
        end
        else
        begin
            pmem_rd_q <= 1'b0;
            if (t4)
            begin
                state_q <= state_d;
                if (flush)
                    pc_q <= pc_d;
                else
                    pc_q <= pc_plus;
                // fetch address for the coming T1
                pmem_addr_q <= flush ? pc_d : pc_plus;
                pmem_rd_q <= 1'b1;
                ir_valid_q <= ir_valid_d;
            end
            else if (t1)
            begin
                // latch fetched word; it executes in the next T2..T4
                ir_q <= pmem_data;
                if (table_rd)
                begin
                    pmem_addr_q <= table_addr;
                    pmem_rd_q <= 1'b1;
                    table_q <= 1'b1;
                end
            end
            else if (table_q)
                table_q <= 1'b0;
            if (t4 && state_q == S_FLUSH)
                state_q <= flush ? S_FLUSH : S_RUN;
        end
    end

    // table word return, one phase after its address
    always @(posedge mclk)
    begin
        if (reset)
        begin
            table_data_q <= {IWW{1'b0}};
            table_valid_q <= 1'b0;
        end
        else
        begin
            table_valid_q <= table_q && instruction_phases_q[1];
            if (table_q && instruction_phases_q[1])
                table_data_q <= pmem_data;
        end
    end

    // alu write back and status in phase four of a valid slot
    always @(posedge mclk)
    begin
        if (reset)
        begin
            acc_q <= 8'h00;
            wb_data_q <= 8'h00;
            wb_en_q <= 1'b0;
            status_q <= 4'h0;
        end
        else
        begin
            wb_en_q <= 1'b0;
            if (t4 && exec_ok && dec_op == `CFPS_OP_ALU)
            begin
                status_q <= alu_status;
                if (dec_to_acc)
                    acc_q <= alu_result;
                else
                begin
                    wb_data_q <= alu_result;
                    wb_en_q <= 1'b1;
                end
            end
            else if (t4 && exec_ok && dec_op == `CFPS_OP_SKIP && !dec_to_acc)
            begin
                // increment/decrement skips with dec_to_acc clear write their result back too
                wb_data_q <= alu_result;
                wb_en_q <= 1'b1;
            end
        end
    end

    // interrupt pending holds while the stack is full
    always @(posedge mclk)
    begin
        if (reset)
        begin
            int_pending_q <= 1'b0;
            int_ack_q <= 1'b0;
            stack_full_q <= 1'b0;
            pc_low_byte_q <= 8'h00;
        end
        else
        begin
            int_ack_q <= push && (pc_d == INT_VECTOR) && int_pending_q &&
                (dec_op != `CFPS_OP_CALL);
            // a new request wins over the clear by acknowledge
            if (int_req)
                int_pending_q <= 1'b1;
            else if (push && int_pending_q && dec_op != `CFPS_OP_CALL)
                int_pending_q <= 1'b0;
            stack_full_q <= full;
            pc_low_byte_q <= pc_q[`CFPS_LOW_BITS-1:0];
        end
    end
endmodule // cfps_core

/* core/cfps_regs.vh */
// constants for the fetch, pc and stack sequencing core
// assumes inclusion by bare name from the core modules
`ifndef CFPS_REGS_VH
`define CFPS_REGS_VH
// phase one-hot codes
`define CFPS_PH_T1 4'h1
`define CFPS_PH_T2 4'h2
`define CFPS_PH_T3 4'h4
`define CFPS_PH_T4 4'h8
// execute operation codes presented by the decoder
`define CFPS_OP_NOP 4'h0
`define CFPS_OP_ALU 4'h1
`define CFPS_OP_JUMP 4'h2
`define CFPS_OP_CALL 4'h3
`define CFPS_OP_RET 4'h4
`define CFPS_OP_INTERRUPT_RETURN 4'h5
`define CFPS_OP_SKIP 4'h6
`define CFPS_OP_PCLW 4'h7
// alu function codes
`define CFPS_ALU_ADD 5'h00
`define CFPS_ALU_ADC 5'h01
`define CFPS_ALU_SUB 5'h02
`define CFPS_ALU_SBC 5'h03
`define CFPS_ALU_DAA 5'h04
`define CFPS_ALU_AND 5'h05
`define CFPS_ALU_OR 5'h06
`define CFPS_ALU_XOR 5'h07
`define CFPS_ALU_CPL 5'h08
`define CFPS_ALU_RR 5'h09
`define CFPS_ALU_RRC 5'h0a
`define CFPS_ALU_RL 5'h0b
`define CFPS_ALU_RLC 5'h0c
`define CFPS_ALU_INC 5'h0d
`define CFPS_ALU_DEC 5'h0e
`define CFPS_ALU_PASS 5'h0f
// status bit positions
`define CFPS_ST_C 0
`define CFPS_ST_AC 1
`define CFPS_ST_Z 2
`define CFPS_ST_OV 3
// pc reset value, pc increment and low byte width
`define CFPS_PC_RESET 12'h000
`define CFPS_PC_ONE 12'h001
`define CFPS_LOW_BITS 8
`endif

/* core/cfps_alu.v */
// 8-bit alu with carry, half carry, zero and overflow results
// assumes operands and function are stable while the execute phase runs
`timescale 1ns/100ps
`include "cfps_regs.vh"
module cfps_alu
(
    // operands
    input wire [7:0] op_a,
    input wire [7:0] op_b,
    input wire carry_in,
    input wire [4:0] func,
    // results
    output reg [7:0] result,
    output reg [3:0] status,
    output reg zero_out
);
    reg [8:0] wide;
    reg [4:0] half;
    reg [7:0] adj;
    // one combinational function table; unused AC and OV are 0, unused C passes carry_in
    always @*
    begin
        wide = 9'h000;
        half = 5'h00;
        adj = 8'h00;
        status = 4'h0;
        case (func)
            `CFPS_ALU_ADD, `CFPS_ALU_ADC:
            begin
                wide = {1'b0, op_a} + {1'b0, op_b} + {8'h00, (func == `CFPS_ALU_ADC) & carry_in};
                half = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} +
                    {4'h0, (func == `CFPS_ALU_ADC) & carry_in};
                status[`CFPS_ST_AC] = half[4];
                status[`CFPS_ST_OV] = (op_a[7] == op_b[7]) && (wide[7] != op_a[7]);
            end
            `CFPS_ALU_SUB, `CFPS_ALU_SBC:
            begin
                // carry set means no borrow
                wide = {1'b0, op_a} + {1'b0, ~op_b} +
                    {8'h00, (func == `CFPS_ALU_SUB) | carry_in};
                half = {1'b0, op_a[3:0]} + {1'b0, ~op_b[3:0]} +
                    {4'h0, (func == `CFPS_ALU_SUB) | carry_in};
                status[`CFPS_ST_AC] = half[4];
                status[`CFPS_ST_OV] = (op_a[7] != op_b[7]) && (wide[7] != op_a[7]);
            end
            `CFPS_ALU_DAA:
            begin
                adj = 8'h00;
                if (op_a[3:0] > 4'h9 || carry_in)
                    adj[3:0] = 4'h6;
                if (op_a > 8'h99 || carry_in)
                    adj[7:4] = 4'h6;
                wide = {1'b0, op_a} + {1'b0, adj};
                wide[8] = wide[8] | (op_a > 8'h99) | carry_in;
            end
            `CFPS_ALU_AND: wide = {1'b0, op_a & op_b};
            `CFPS_ALU_OR: wide = {1'b0, op_a | op_b};
            `CFPS_ALU_XOR: wide = {1'b0, op_a ^ op_b};
            `CFPS_ALU_CPL: wide = {1'b0, ~op_a};
            `CFPS_ALU_RR: wide = {1'b0, op_a[0], op_a[7:1]};
            `CFPS_ALU_RRC: wide = {op_a[0], carry_in, op_a[7:1]};
            `CFPS_ALU_RL: wide = {1'b0, op_a[6:0], op_a[7]};
            `CFPS_ALU_RLC: wide = {op_a[7], op_a[6:0], carry_in};
            `CFPS_ALU_INC: wide = {1'b0, op_a + 8'h01};
            `CFPS_ALU_DEC: wide = {1'b0, op_a - 8'h01};
            default: wide = {1'b0, op_a};
        endcase
        result = wide[7:0];
        // only arithmetic and rotate-through-carry touch carry
        case (func)
            `CFPS_ALU_ADD, `CFPS_ALU_ADC, `CFPS_ALU_SUB, `CFPS_ALU_SBC,
            `CFPS_ALU_DAA, `CFPS_ALU_RRC, `CFPS_ALU_RLC:
                status[`CFPS_ST_C] = wide[8];
            default: status[`CFPS_ST_C] = carry_in;
        endcase
        status[`CFPS_ST_Z] = (wide[7:0] == 8'h00);
        zero_out = (wide[7:0] == 8'h00);
    end
endmodule // cfps_alu

/* core/cfps_stack.v */
// return stack holding program counter values only
// assumes push and pop never arrive in the same cycle
`timescale 1ns/100ps
`include "cfps_regs.vh"
module cfps_stack
#(
    parameter DEPTH = 8,
    parameter IW = 3,
    parameter PCW = 12
)
(
    // clock and reset
    input wire mclk,
    input wire reset,
    // push and pop
    input wire push,
    input wire pop,
    input wire [PCW-1:0] push_value,
    output wire [PCW-1:0] top_value,
    // fill state
    output wire full,
    output wire empty
);
    reg [PCW-1:0] mem_q [0:DEPTH-1];
    reg [IW:0] stack_index_q;
    wire [IW-1:0] wr_slot;
    wire [IW-1:0] rd_slot;
    // index counts stored levels; overflow wraps and overwrites the oldest
    assign wr_slot = stack_index_q[IW-1:0];
    assign rd_slot = stack_index_q[IW-1:0] - {{(IW-1){1'b0}}, 1'b1};
    assign top_value = mem_q[rd_slot];
    assign full = ({{(31-IW){1'b0}}, stack_index_q} == DEPTH);
    assign empty = (stack_index_q == {(IW+1){1'b0}});
    // index update
    always @(posedge mclk)
    begin
        if (reset)
            stack_index_q <= {(IW+1){1'b0}};
        else if (push)
        begin
            if (full)
                stack_index_q <= {{IW{1'b0}}, 1'b1};
            else
                stack_index_q <= stack_index_q + {{IW{1'b0}}, 1'b1};
        end
        else if (pop && !empty)
            stack_index_q <= stack_index_q - {{IW{1'b0}}, 1'b1};
    end
    // storage, no reset needed for data
    always @(posedge mclk)
    begin
        if (push)
            mem_q[wr_slot] <= push_value;
    end
endmodule // cfps_stack

/* test/cfps_pmem_model.sv */
// program memory model: answers a fetch with a word built from its address
// assumes the core holds pmem_addr_q steady while the word is being taken
`timescale 1ns/100ps
module cfps_pmem_model
#(
    parameter PCW = 12,
    parameter IWW = 15
)
(
    // fetch side
    input wire mclk,
    input wire rd,
    input wire [PCW-1:0] addr,
    // word out
    output logic [IWW-1:0] data
);
    logic hold_q = 1'b0;
    logic [IWW-1:0] last_q = '0;
    // word valid in the read cycle and the next; otherwise the inverse of the last output, so stale data toggles each cycle
    always @(posedge mclk)
    begin
        hold_q <= rd;
        last_q <= data;
    end
    assign data = (rd || hold_q) ? {3'h5, addr} : ~last_q;
endmodule // cfps_pmem_model

/* test/cfps_core_checker.sv */
// concurrent checks on the sequencing core ports
// assumes binding into cfps_core, one clock domain, sync reset
`timescale 1ns/100ps
`include "cfps_regs.vh"
module cfps_core_checker
#(
    parameter PCW = 12,
    parameter [PCW-1:0] INT_VECTOR = 12'h004
)
(
    // clock and reset
    input wire mclk,
    input wire reset,
    // watched outputs
    input wire [PCW-1:0] pmem_addr_q,
    input wire pmem_rd_q,
    input wire table_valid_q,
    input wire wb_en_q,
    input wire int_ack_q,
    input wire int_pending_q,
    input wire [3:0] instruction_phases_q,
    input wire stack_full_q
);
    logic [3:0] ph_prev_q;
    // previous phase, avoids bit selects on a sampled value
    always @(posedge mclk)
        ph_prev_q <= instruction_phases_q;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    chk_phase_onehot: assert property ($onehot(instruction_phases_q))
        else $error("phase code not one-hot");
    chk_phase_rotate: assert property (
        !$past(reset) |-> instruction_phases_q == {ph_prev_q[2:0], ph_prev_q[3]})
        else $error("phase did not advance by one");
    chk_fetch_first: assert property (
        instruction_phases_q == `CFPS_PH_T1 && !$past(reset) |-> pmem_rd_q)
        else $error("no fetch in first phase");
    chk_table_fetch: assert property (
        pmem_rd_q && instruction_phases_q != `CFPS_PH_T1 |->
        instruction_phases_q == `CFPS_PH_T2 ##1 table_valid_q)
        else $error("memory read outside fetch and table slots");
    chk_fetch_rate: assert property (
        pmem_rd_q && instruction_phases_q == `CFPS_PH_T1 |=> ##1 !pmem_rd_q [*2] ##1 pmem_rd_q)
        else $error("fetches not one per instruction cycle");
    chk_ack_pulse: assert property (int_ack_q |=> !int_ack_q)
        else $error("acknowledge longer than one cycle");
    chk_ack_cause: assert property (
        $rose(int_ack_q) |-> $past(int_pending_q) && !$past(stack_full_q))
        else $error("acknowledge without pending request or with full stack");
    chk_full_holds: assert property (stack_full_q && int_pending_q |=> !int_ack_q)
        else $error("acknowledge while stack full");
    chk_ack_vector: assert property (
        int_ack_q |-> ##[0:8] (pmem_rd_q && pmem_addr_q == INT_VECTOR))
        else $error("no fetch from interrupt vector");
    chk_wb_pulse: assert property (wb_en_q |=> !wb_en_q)
        else $error("write back longer than one cycle");
    chk_table_slot: assert property (table_valid_q |-> instruction_phases_q == `CFPS_PH_T3 ##1 !table_valid_q)
        else $error("table data outside third phase");
endmodule // cfps_core_checker

/* test/cfps_core_test.sv */
// self-checking bench for the sequencing core with a program memory model
// assumes the model and checker are compiled first; stack depth cut to 4
`timescale 1ns/100ps
`include "cfps_regs.vh"
module cfps_core_test;
    localparam PCW = 12;
    localparam DEPTH = 4;
    logic mclk = 0, reset = 1, table_rd = 0, dec_skip_on_zero = 0, dec_to_acc = 1;
    logic pcl_wr = 0, int_req = 0, pmem_rd_q, table_valid_q, wb_en_q, int_ack_q;
    logic int_pending_q, ir_valid_q, stack_full_q;
    logic [PCW-1:0] table_addr = '0, dec_target = '0, pmem_addr_q, lastf;
    logic [14:0] pmem_data, table_data_q, ir_q;
    logic [3:0] dec_op = 4'h0, status_q, instruction_phases_q;
    logic [4:0] dec_alu_func = 5'h00;
    logic [7:0] mem_operand = 8'h00, pcl_wdata = 8'h00, acc_q, pc_low_byte_q, wb_data_q;
    logic [PCW-1:0] fq [$];
    integer miscompares = 0, comparisons = 0, dummies = 0, acks = 0, d0, a0, n;
    always #20 mclk = ~mclk;
    cfps_core #(.DEPTH(DEPTH), .IW(2)) u_dut
    (
        .mclk(mclk), .reset(reset), .pmem_addr_q(pmem_addr_q), .pmem_rd_q(pmem_rd_q),
        .pmem_data(pmem_data), .table_rd(table_rd), .table_addr(table_addr),
        .table_data_q(table_data_q), .table_valid_q(table_valid_q), .dec_op(dec_op),
        .dec_target(dec_target), .dec_alu_func(dec_alu_func),
        .dec_skip_on_zero(dec_skip_on_zero), .dec_to_acc(dec_to_acc),
        .mem_operand(mem_operand), .acc_q(acc_q), .wb_data_q(wb_data_q), .wb_en_q(wb_en_q),
        .status_q(status_q), .pcl_wr(pcl_wr), .pcl_wdata(pcl_wdata),
        .pc_low_byte_q(pc_low_byte_q), .int_req(int_req), .int_ack_q(int_ack_q),
        .int_pending_q(int_pending_q), .instruction_phases_q(instruction_phases_q),
        .ir_q(ir_q), .ir_valid_q(ir_valid_q), .stack_full_q(stack_full_q)
    );
    cfps_pmem_model #(.PCW(PCW), .IWW(15)) u_pmem
    (
        .mclk(mclk), .rd(pmem_rd_q), .addr(pmem_addr_q), .data(pmem_data)
    );
    // fetch log, dummy slot and acknowledge counters
    always @(posedge mclk)
    begin
        if (pmem_rd_q === 1'b1)
            fq.push_back(pmem_addr_q);
        if (!reset && instruction_phases_q === `CFPS_PH_T4 && ir_valid_q === 1'b0)
            dummies = dummies + 1;
        if (int_ack_q === 1'b1)
            acks = acks + 1;
    end
    task check_val(input string name, input logic [15:0] e, input logic [15:0] g);
        comparisons = comparisons + 1;
        if (g !== e)
        begin
            miscompares = miscompares + 1;
            $display("unexpected %s expected %h seen %h", name, e, g);
        end
    endtask
    // second fetch of the log is the first one after the decision
    task check_fetch(input string name, input logic [PCW-1:0] e);
        check_val(name, {4'h0, e}, (fq.size() > 1) ? {4'h0, fq[1]} : 16'hffff);
    endtask
    task at_t1;
        n = 0;
        do
        begin
            @(posedge mclk);
            #1 n = n + 1;
        end
        while (instruction_phases_q !== `CFPS_PH_T1 && n < 8);
    endtask
    // present one decoded instruction, retrying past dummy slots
    task exec(input [3:0] op, input [PCW-1:0] tgt, input [4:0] fn, input skz, input ta,
        input [7:0] b);
        integer k;
        k = 0;
        do
        begin
            at_t1;
            fq.delete();
            dec_op = op;
            dec_target = tgt;
            dec_alu_func = fn;
            dec_skip_on_zero = skz;
            dec_to_acc = ta;
            mem_operand = b;
            pcl_wdata = b;
            pcl_wr = (op == `CFPS_OP_PCLW);
            repeat (3) @(posedge mclk);
            #1 k = k + 1;
        end
        while (ir_valid_q !== 1'b1 && k < 4);
        lastf = fq[$];
        // the model answers every fetch with its address under a fixed tag
        check_val("fetched word", {1'b0, 3'h5, lastf}, {1'b0, ir_q});
        d0 = dummies;
        @(posedge mclk);
        #1 dec_op = `CFPS_OP_NOP;
        pcl_wr = 0;
        repeat (12) @(posedge mclk);
        #1;
    endtask
    task alu_step(input [4:0] fn, input ta, input [7:0] b, input [7:0] ea, input [3:0] m,
        input [3:0] es);
        exec(`CFPS_OP_ALU, '0, fn, 0, ta, b);
        check_val("acc", {8'h00, ea}, {8'h00, acc_q});
        check_val("status", {12'h000, es}, {12'h000, status_q & m});
    endtask
    task t_reset;
        check_val("phases", 16'h0001, {12'h000, instruction_phases_q});
        check_val("stack full", 16'h0000, {15'h0, stack_full_q});
        check_val("pc low", 16'h0000, {8'h00, pc_low_byte_q});
        #1 reset = 0;
    endtask
    task t_flow;
        exec(`CFPS_OP_NOP, '0, 5'h00, 0, 1, 8'h00);
        check_val("next fetch", {4'h0, fq[0] + 12'h001}, {4'h0, fq[1]});
        exec(`CFPS_OP_JUMP, 12'h3a0, 5'h00, 0, 1, 8'h00);
        check_fetch("jump fetch", 12'h3a0);
        check_val("jump dummies", 16'h0001, dummies - d0);
        exec(`CFPS_OP_PCLW, '0, 5'h00, 0, 1, 8'h55);
        check_fetch("page fetch", 12'h355);
        check_val("page dummies", 16'h0001, dummies - d0);
    endtask
    task t_call;
        logic [PCW-1:0] ra;
        exec(`CFPS_OP_CALL, 12'h200, 5'h00, 0, 1, 8'h00);
        // return resumes at the word after the call
        ra = lastf + 12'h001;
        check_fetch("call fetch", 12'h200);
        exec(`CFPS_OP_RET, '0, 5'h00, 0, 1, 8'h00);
        check_fetch("return fetch", ra);
    endtask
    task t_alu;
        alu_step(`CFPS_ALU_ADD, 1, 8'h3c, 8'h3c, 4'h1, 4'h0);
        alu_step(`CFPS_ALU_ADD, 1, 8'hf0, 8'h2c, 4'h1, 4'h1);
        alu_step(`CFPS_ALU_AND, 1, 8'h0f, 8'h0c, 4'h0, 4'h0);
        alu_step(`CFPS_ALU_OR, 1, 8'h50, 8'h5c, 4'h0, 4'h0);
        alu_step(`CFPS_ALU_XOR, 1, 8'h5c, 8'h00, 4'h4, 4'h4);
        alu_step(`CFPS_ALU_ADD, 0, 8'h01, 8'h00, 4'h0, 4'h0);
        check_val("write back", 16'h0001, {8'h00, wb_data_q});
        exec(`CFPS_OP_SKIP, '0, `CFPS_ALU_ADD, 1, 1, 8'h00);
        check_val("skip dummies", 16'h0001, dummies - d0);
        exec(`CFPS_OP_SKIP, '0, `CFPS_ALU_ADD, 0, 1, 8'h00);
        check_val("no skip dummies", 16'h0000, dummies - d0);
    endtask
    task t_table;
        at_t1;
        table_rd = 1;
        table_addr = 12'h0a5;
        n = 0;
        while (table_valid_q !== 1'b1 && n < 8)
        begin
            @(posedge mclk);
            #1 n = n + 1;
        end
        check_val("table data", {1'b0, 3'h5, 12'h0a5}, {1'b0, table_data_q});
        table_rd = 0;
    endtask
    // full stack holds the interrupt back until a return, yet a call still runs
    task t_int_full;
        for (int i = 0; i < DEPTH; i++)
            exec(`CFPS_OP_CALL, 12'h100 + i, 5'h00, 0, 1, 8'h00);
        check_val("full", 16'h0001, {15'h0, stack_full_q});
        a0 = acks;
        int_req = 1;
        @(posedge mclk);
        #1 int_req = 0;
        repeat (16) @(posedge mclk);
        #1 check_val("pending", 16'h0001, {15'h0, int_pending_q});
        check_val("held acks", 16'h0000, acks - a0);
        exec(`CFPS_OP_RET, '0, 5'h00, 0, 1, 8'h00);
        check_val("acks", 16'h0001, acks - a0);
        exec(`CFPS_OP_CALL, 12'h2f0, 5'h00, 0, 1, 8'h00);
        check_fetch("overflow call", 12'h2f0);
        reset = 1;
        repeat (2) @(posedge mclk);
        #1 reset = 0;
        @(posedge mclk);
        #1 check_val("full after reset", 16'h0000, {15'h0, stack_full_q});
    endtask
    task results;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge mclk);
        t_reset;
        t_flow;
        t_call;
        t_alu;
        t_table;
        t_int_full;
        results;
    end
    // watchdog, far beyond the roughly 430 cycles the scenarios need
    initial
    begin
        #400000;
        miscompares = miscompares + 1;
        results;
    end
endmodule // cfps_core_test
bind cfps_core cfps_core_checker #(.PCW(PCW), .INT_VECTOR(INT_VECTOR)) u_chk
(
    .mclk(mclk), .reset(reset), .pmem_addr_q(pmem_addr_q), .pmem_rd_q(pmem_rd_q),
    .table_valid_q(table_valid_q), .wb_en_q(wb_en_q), .int_ack_q(int_ack_q),
    .int_pending_q(int_pending_q), .instruction_phases_q(instruction_phases_q),
    .stack_full_q(stack_full_q)
);
